// [rtl/dcps_regs.svh]
`ifndef DCPS_REGS_SVH
`define DCPS_REGS_SVH
// register byte offsets
`define DCPS_CTRL_OFS       8'h00
`define DCPS_STAT_OFS       8'h04
`define DCPS_RXS_OFS        8'h10
`define DCPS_TXS_OFS        8'h20
// ctrl fields
`define DCPS_CTRL_LIN_BIT   0
`define DCPS_CTRL_RST       32'h0000_0000
// status fields
`define DCPS_STAT_SSI_BIT   0
`define DCPS_STAT_M1_LSB    1
`define DCPS_STAT_M2_LSB    3
`define DCPS_STAT_LAW_BIT   5
`define DCPS_STAT_FMT_BIT   6
`define DCPS_STAT_FCNT_LSB  16
// companded code inversion masks
`define DCPS_ALAW_XOR       8'h55
`define DCPS_MULAW_XOR      8'h7F
// slot widths in bits
`define DCPS_SLOT_NARROW    5'h08
`define DCPS_SLOT_WIDE      5'h10
// frame period, bit rate limits and system clock
`define DCPS_FRAME_US       125
`define DCPS_RATE_MIN_KBPS  128
`define DCPS_RATE_MAX_KBPS  4096
`define DCPS_CLK_MHZ        125
`endif

// [rtl/dcps_pkg.sv]
package dcps_pkg;
    // frame-bus slot placement selected by a strobe pin pair
    typedef enum logic [1:0] {
        DCPS_FB_NARROW_LOW,
        DCPS_FB_WIDE_LOW,
        DCPS_FB_NARROW_HIGH,
        DCPS_FB_WIDE_HIGH
    } dcps_fb_mode_t;
    // axi-lite write acceptance state
    typedef enum logic [1:0] {
        DCPS_WR_IDLE,
        DCPS_WR_RESP
    } dcps_wr_st_t;
endpackage : dcps_pkg

// [rtl/dcps_serial_port.sv]
// Design decisions made here: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "dcps_regs.svh"
module dcps_serial_port
    import dcps_pkg::*;
#(
    parameter int CNT_W = 10
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // serial link pins
    input  wire logic        bit_clk,
    input  wire logic        frame_n,
    input  wire logic        strobe_serial_mode,
    input  wire logic        strobe_a_rx_pair,
    input  wire logic        strobe_b_rx_pair,
    input  wire logic        strobe_a_tx_pair,
    input  wire logic        strobe_b_tx_pair,
    input  wire logic        rx_ref_in,
    input  wire logic        tx_send_in,
    output logic             tx_send_out,
    output logic             tx_send_out_oe_n,
    output logic             rx_ref_out,
    output logic             rx_ref_out_oe_n,
    // code selection pins
    input  wire logic        law_sel,
    input  wire logic        code_fmt,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    // a frame at the top rate holds 512 bits
    if (CNT_W < 9 || CNT_W > 16) begin : g_bad_cnt_w
        $error("CNT_W must be 9..16");
    end

    localparam int NPIN = 11;

    // two-flop synchroniser for every pin input
    logic [NPIN-1:0] meta_q;
    logic [NPIN-1:0] sync_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= {code_fmt, law_sel, tx_send_in, rx_ref_in, strobe_b_tx_pair,
                       strobe_a_tx_pair, strobe_b_rx_pair, strobe_a_rx_pair,
                       strobe_serial_mode, frame_n, bit_clk};
            sync_q <= meta_q;
        end
    end

    logic       bclk_s, frame_n_s, ssi_s, rin_s, sin_s, law_s, fmt_s;
    logic [3:0] strobe_s;
    assign bclk_s    = sync_q[0];
    assign frame_n_s = sync_q[1];
    assign ssi_s     = sync_q[2];
    assign strobe_s  = sync_q[6:3];
    assign rin_s     = sync_q[7];
    assign sin_s     = sync_q[8];
    assign law_s     = sync_q[9];
    assign fmt_s     = sync_q[10];

    // bit clock edge finder on the synchronised copy
    logic bclk_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) bclk_q <= 1'b0;
        else       bclk_q <= bclk_s;
    end
    logic bclk_fall;
    assign bclk_fall = bclk_q & ~bclk_s;

    // frame-bus bit position, cleared by the frame pulse
    logic [CNT_W-1:0] gcnt_q;
    logic [15:0]      fcnt_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            gcnt_q <= '0;
            fcnt_q <= '0;
        end else if (bclk_fall) begin
            if (!frame_n_s) begin
                gcnt_q <= '0;
                fcnt_q <= fcnt_q + 16'h0001;
            end else begin
                gcnt_q <= gcnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // strobe pins double as frame-bus mode selects per pin pair
    dcps_fb_mode_t mode_rx, mode_tx;
    assign mode_rx = dcps_fb_mode_t'(strobe_s[1:0]);
    assign mode_tx = dcps_fb_mode_t'(strobe_s[3:2]);

    // software control and sample stores
    logic [31:0] ctrl_q;
    logic [15:0] rxs_q [4];
    logic [15:0] txs_q [4];
    logic        lin;
    assign lin = ctrl_q[`DCPS_CTRL_LIN_BIT];

    // companded code to and from sign-magnitude; the xor is its own inverse
    function automatic logic [7:0] code_swap(input logic [7:0] c, input logic fmt,
                                             input logic law);
        logic [7:0] m;
        m = law ? `DCPS_ALAW_XOR : `DCPS_MULAW_XOR;
        code_swap = fmt ? (c ^ m) : c;
    endfunction : code_swap

    // per-lane slot logic: lanes 0,1 on rx pair, 2,3 on tx pair
    logic [3:0]  en;
    logic [3:0]  act_q;
    logic [3:0]  obit;
    logic [4:0]  bits_q [4];
    logic [15:0] ish_q  [4];
    logic [15:0] osh_q  [4];

    for (genvar i = 0; i < 4; i++) begin : g_lane
        dcps_fb_mode_t md;
        logic [4:0]       wid;
        logic [CNT_W-1:0] base;
        logic [CNT_W-1:0] lo;
        logic             din;
        logic [15:0]      load;
        assign md   = (i < 2) ? mode_rx : mode_tx;
        assign wid  = md[0] ? `DCPS_SLOT_WIDE : `DCPS_SLOT_NARROW;
        assign base = md[1] ? CNT_W'({wid, 1'b0}) : '0;
        assign lo   = base + ((i % 2 == 1) ? CNT_W'(wid) : '0);
        assign din  = (i < 2) ? rin_s : sin_s;
        // strobe gates the lane, else its frame-bus slot does
        assign en[i] = ssi_s ? strobe_s[i]
                     : (gcnt_q >= lo && gcnt_q < lo + CNT_W'(wid));
        assign load = lin ? txs_q[i] : {code_swap(txs_q[i][7:0], fmt_s, law_s), 8'h00};
        assign obit[i] = osh_q[i][15];

        // shift in on falling bit clock while enabled, shift out after it
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                act_q[i]  <= 1'b0;
                bits_q[i] <= '0;
                ish_q[i]  <= '0;
                osh_q[i]  <= '0;
            end else if (!en[i]) begin
                act_q[i]  <= 1'b0;
                bits_q[i] <= '0;
                osh_q[i]  <= load;
            end else if (bclk_fall) begin
                act_q[i]  <= 1'b1;
                ish_q[i]  <= {ish_q[i][14:0], din};
                osh_q[i]  <= {osh_q[i][14:0], 1'b0};
                bits_q[i] <= bits_q[i] + 5'h01;
            end else begin
                act_q[i]  <= 1'b1;
            end
        end

        // close of slot stores the sample; narrow companded codes are converted to sign-magnitude, linear or wide ones stored as shifted in
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                rxs_q[i] <= '0;
            end else if (act_q[i] && !en[i]) begin
                if (lin || bits_q[i] >= `DCPS_SLOT_WIDE)
                    rxs_q[i] <= ish_q[i];
                else
                    rxs_q[i] <= {8'h00, code_swap(ish_q[i][7:0], fmt_s, law_s)};
            end
        end
    end

    // output pins: each pair driven only by an enabled lane
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_send_out      <= 1'b0;
            tx_send_out_oe_n <= 1'b1;
            rx_ref_out       <= 1'b0;
            rx_ref_out_oe_n  <= 1'b1;
        end else begin
            tx_send_out      <= (en[0] & obit[0]) | (en[1] & obit[1]);
            tx_send_out_oe_n <= ~(en[0] | en[1]);
            rx_ref_out       <= (en[2] & obit[2]) | (en[3] & obit[3]);
            rx_ref_out_oe_n  <= ~(en[2] | en[3]);
        end
    end

    // axi write: address and data taken in either order
    logic       aw_q, w_q;
    logic [7:0] awa_q;
    logic [31:0] wd_q;
    logic [3:0]  ws_q; // byte strobes travel with the data
    assign s_axi_awready = ~aw_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_q & ~s_axi_bvalid;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_q <= 1'b0;
            w_q  <= 1'b0;
            awa_q <= '0;
            wd_q  <= '0;
            ws_q  <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q  <= 1'b1;
                awa_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q  <= 1'b1;
                wd_q <= s_axi_wdata;
                ws_q <= s_axi_wstrb;
            end
            if (aw_q && w_q) begin
                aw_q <= 1'b0;
                w_q  <= 1'b0;
            end
        end
    end

    // write decode and response
    logic wr_ok;
    assign wr_ok = (awa_q == `DCPS_CTRL_OFS) || (awa_q[7:4] == `DCPS_TXS_OFS >> 4
                   && awa_q[1:0] == 2'b00);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_q       <= `DCPS_CTRL_RST;
            for (int k = 0; k < 4; k++) txs_q[k] <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else if (aw_q && w_q) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? 2'b00 : 2'b10;
            if (awa_q == `DCPS_CTRL_OFS && ws_q[0])
                ctrl_q[0] <= wd_q[0];
            if (wr_ok && awa_q != `DCPS_CTRL_OFS) begin
                if (ws_q[0]) txs_q[awa_q[3:2]][7:0]  <= wd_q[7:0];
                if (ws_q[1]) txs_q[awa_q[3:2]][15:8] <= wd_q[15:8];
            end
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // read decode
    logic [31:0] stat;
    assign stat = {fcnt_q, 9'h000, fmt_s, law_s, strobe_s[3:2], strobe_s[1:0], ssi_s};
    assign s_axi_arready = ~s_axi_rvalid;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            if (s_axi_araddr == `DCPS_CTRL_OFS)
                s_axi_rdata <= ctrl_q;
            else if (s_axi_araddr == `DCPS_STAT_OFS)
                s_axi_rdata <= stat;
            else if (s_axi_araddr[7:4] == `DCPS_RXS_OFS >> 4 && s_axi_araddr[1:0] == 2'b00)
                s_axi_rdata <= {16'h0000, rxs_q[s_axi_araddr[3:2]]};
            else if (s_axi_araddr[7:4] == `DCPS_TXS_OFS >> 4 && s_axi_araddr[1:0] == 2'b00)
                s_axi_rdata <= {16'h0000, txs_q[s_axi_araddr[3:2]]};
            else begin
                s_axi_rdata <= '0;
                s_axi_rresp <= 2'b10;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule : dcps_serial_port

// [dv/dcps_serial_port_assertions.sv]
`timescale 1ns/1ps
// serial lane enable and output checks
module dcps_serial_port_chk (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // link pins
    input wire logic bit_clk,
    input wire logic strobe_serial_mode,
    input wire logic strobe_a_rx_pair,
    input wire logic strobe_b_rx_pair,
    input wire logic strobe_a_tx_pair,
    input wire logic strobe_b_tx_pair,
    input wire logic tx_send_out,
    input wire logic tx_send_out_oe_n,
    input wire logic rx_ref_out,
    input wire logic rx_ref_out_oe_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_tx_idle;
        (strobe_serial_mode && !strobe_a_rx_pair && !strobe_b_rx_pair)[*6] |->
            tx_send_out_oe_n && !tx_send_out;
    endproperty
    a_tx_idle: assert property (p_tx_idle) else $error("tx out not idle");
    property p_rx_idle;
        (strobe_serial_mode && !strobe_a_tx_pair && !strobe_b_tx_pair)[*6] |->
            rx_ref_out_oe_n && !rx_ref_out;
    endproperty
    a_rx_idle: assert property (p_rx_idle) else $error("rx out not idle");
    property p_tx_on;
        (strobe_serial_mode && strobe_a_rx_pair)[*6] |-> !tx_send_out_oe_n;
    endproperty
    a_tx_on: assert property (p_tx_on) else $error("tx out not enabled");
    property p_rx_on;
        (strobe_serial_mode && strobe_b_tx_pair)[*6] |-> !rx_ref_out_oe_n;
    endproperty
    a_rx_on: assert property (p_rx_on) else $error("rx out not enabled");
    property p_tx_drop;
        $fell(strobe_a_rx_pair) && !strobe_b_rx_pair && strobe_serial_mode |->
            ##[1:6] tx_send_out_oe_n;
    endproperty
    a_tx_drop: assert property (p_tx_drop) else $error("tx out kept on");
    property p_rx_drop;
        $fell(strobe_a_tx_pair) && !strobe_b_tx_pair && strobe_serial_mode |->
            ##[1:6] rx_ref_out_oe_n;
    endproperty
    a_rx_drop: assert property (p_rx_drop) else $error("rx out kept on");
    property p_tx_hold;
        (bit_clk && strobe_a_rx_pair)[*6] |-> $stable(tx_send_out);
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx out moved");
    property p_rx_hold;
        (bit_clk && strobe_b_tx_pair)[*6] |-> $stable(rx_ref_out);
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("rx out moved");
endmodule : dcps_serial_port_chk

bind dcps_serial_port dcps_serial_port_chk u_chk (.clk, .nrst, .bit_clk,
    .strobe_serial_mode, .strobe_a_rx_pair, .strobe_b_rx_pair, .strobe_a_tx_pair,
    .strobe_b_tx_pair, .tx_send_out, .tx_send_out_oe_n, .rx_ref_out, .rx_ref_out_oe_n);

// [dv/dcps_pcm_far_end.sv]
`timescale 1ns/1ps
// far-end pcm highway, bit clock still between slots
module dcps_pcm_far_end (
    // driven pins
    output logic       bit_clk,
    output logic       frame_n,
    output logic [3:0] en,
    output logic       rx_ref_in,
    output logic       tx_send_in,
    // observed pins
    input wire logic   tx_send_out,
    input wire logic   rx_ref_out
);
    realtime t0 = -1.0;
    initial begin
        bit_clk = 1'h1;
        frame_n = 1'h1;
        en = 4'h0;
        rx_ref_in = 1'h0;
        tx_send_in = 1'h0;
    end
    // one slot, msb first, collects output bits
    task automatic slot(input int ln, input int n, input logic [15:0] d,
                        output logic [15:0] q);
        q = 16'h0000;
        en[ln] = 1'h1;
        for (int i = n - 1; i >= 0; i--) begin
            if (ln < 2)
                rx_ref_in = d[i];
            else
                tx_send_in = d[i];
            // output moves after a fall, so read it just before the next one
            #62.5 q = {q[14:0], (ln < 2) ? tx_send_out : rx_ref_out};
            bit_clk = 1'h0;
            #62.5 bit_clk = 1'h1;
        end
        #62.5 en[ln] = 1'h0;
        rx_ref_in = ~rx_ref_in; // released lines flip
        tx_send_in = ~tx_send_in;
        #62.5;
    endtask : slot
    // a-rx strobe always first, frames one period apart
    task automatic frame(input int ln, input int n, input logic [15:0] d,
                         output logic [15:0] q);
        if (t0 >= 0.0)
            #(t0 + 125000.0 - $realtime);
        t0 = $realtime;
        slot(0, n, d, q);
        if (ln != 0)
            slot(ln, n, d, q);
    endtask : frame
    // strobe pins held as frame-bus mode selects
    task automatic hold_en(input logic [3:0] v);
        en = v;
    endtask : hold_en
    // frame-bus frame: pulse at the first fall, then n rx-pin bits
    task automatic fb_frame(input int n, input logic [63:0] d, output logic [63:0] q);
        q = 64'h0;
        frame_n = 1'h0;
        #62.5 bit_clk = 1'h0;
        #62.5 bit_clk = 1'h1;
        frame_n = 1'h1;
        for (int i = n - 1; i >= 0; i--) begin
            rx_ref_in = d[i];
            #62.5 q = {q[62:0], tx_send_out};
            bit_clk = 1'h0;
            #62.5 bit_clk = 1'h1;
        end
        #125;
    endtask : fb_frame
endmodule : dcps_pcm_far_end

// [dv/test_dual_canceller_pcm_serial_port.sv]
`timescale 1ns/1ps
`include "dcps_regs.svh"
module test_dual_canceller_pcm_serial_port;
    logic clk = 1'h0, nrst = 1'h0, ssm = 1'h1, law = 1'h0, fmt = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    wire awready, wready, bvalid, arready, rvalid, bck, rin, sin, tout, toe, rout, roe, fpn;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [3:0] en;
    int fail_count = 0, check_count = 0, cyc = 0;
    typedef struct packed {
        logic law, fmt, lin;
        logic [1:0] ln;
        logic two;
        logic [15:0] din, tx, erx, eout;
    } dcps_row_t;
    dcps_row_t rows [4] = '{
        '{1'h0, 1'h0, 1'h0, 2'h1, 1'h0, 16'h0093, 16'h0047, 16'h0093, 16'h0000},
        '{1'h0, 1'h0, 1'h1, 2'h3, 1'h1, 16'hA5C3, 16'h3C5A, 16'hA5C3, 16'h3C5A},
        '{1'h1, 1'h1, 1'h0, 2'h2, 1'h1, 16'h0093, 16'h0047, 16'h00C6, 16'h0012},
        '{1'h0, 1'h1, 1'h0, 2'h0, 1'h0, 16'h0093, 16'h0047, 16'h00EC, 16'h0000}};
    // system clock
    always #4 clk = ~clk;
    dcps_serial_port dut (.clk(clk), .nrst(nrst), .bit_clk(bck), .frame_n(fpn),
        .strobe_serial_mode(ssm), .strobe_a_rx_pair(en[0]), .strobe_b_rx_pair(en[1]),
        .strobe_a_tx_pair(en[2]), .strobe_b_tx_pair(en[3]), .rx_ref_in(rin),
        .tx_send_in(sin), .tx_send_out(tout), .tx_send_out_oe_n(toe), .rx_ref_out(rout),
        .rx_ref_out_oe_n(roe), .law_sel(law), .code_fmt(fmt), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    dcps_pcm_far_end far (.bit_clk(bck), .frame_n(fpn), .en(en), .rx_ref_in(rin), .tx_send_in(sin),
        .tx_send_out(tout), .rx_ref_out(rout));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'h0;
    endtask : rd
    task automatic test_done;
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 99000) begin
            fail_count++;
            test_done;
        end
    end
    // table rows, then bus errors and mode pins
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [15:0] q;
        logic [63:0] q64;
        repeat (16) @(posedge clk);
        nrst <= 1'h1;
        rd(`DCPS_CTRL_OFS, d, r);
        chk("ctrl reset", 32'h0000_0000, d);
        foreach (rows[i]) begin
            law <= rows[i].law;
            fmt <= rows[i].fmt;
            wr(`DCPS_CTRL_OFS, {31'h0, rows[i].lin}, r);
            wr(`DCPS_TXS_OFS + {4'h0, rows[i].ln, 2'h0}, {16'h0000, rows[i].tx}, r);
            repeat (rows[i].two + 1)
                far.frame(rows[i].ln, rows[i].lin ? `DCPS_SLOT_WIDE : `DCPS_SLOT_NARROW,
                          rows[i].din, q);
            if (rows[i].two)
                chk("serial out", {16'h0, rows[i].eout}, {16'h0, q});
            rd(`DCPS_RXS_OFS + {4'h0, rows[i].ln, 2'h0}, d, r);
            chk("rx sample", {16'h0, rows[i].erx}, d);
        end
        rd(8'hFC, d, r);
        chk("bad read resp", 32'h0000_0002, {30'h0, r});
        chk("bad read data", 32'h0000_0000, d);
        wr(8'hF0, 32'hFFFF_FFFF, r);
        chk("bad write resp", 32'h0000_0002, {30'h0, r});
        ssm <= 1'h0;
        for (int k = 0; k < 4; k++) begin
            far.hold_en({~k[1:0], k[1:0]});
            law <= k[0];
            fmt <= k[1];
            repeat (4) @(posedge clk);
            rd(`DCPS_STAT_OFS, d, r);
            chk("mode pins", {25'h0, k[1:0], ~k[1:0], k[1:0], 1'h0}, d & 32'h0000_007F);
        end
        // frame-bus: rx pair wide slots from bit 32, lane a then lane b
        far.hold_en(4'h3);
        law <= 1'h0;
        fmt <= 1'h0;
        repeat (4) @(posedge clk);
        far.fb_frame(64, 64'h1234_5678_9ABC_DEF0, q64);
        chk("fb out lanes", 32'h4700_4700, q64[31:0]);
        chk("fb out idle", 32'h0000_0000, q64[63:32]);
        rd(`DCPS_RXS_OFS, d, r);
        chk("fb rx a", 32'h0000_9ABC, d);
        rd(`DCPS_RXS_OFS + 8'h04, d, r);
        chk("fb rx b", 32'h0000_DEF0, d);
        rd(`DCPS_STAT_OFS, d, r);
        chk("fb status", 32'h0001_0006, d);
        test_done;
    end
endmodule : test_dual_canceller_pcm_serial_port
